// file: src/cpom_core.sv
// Operand decode, register file, accumulator and cycle count model.
// Assumes requests come from logic on clk; the clock gear and intermittent
// mode bits are stable core-domain levels.
`timescale 1ns/1ns
`default_nettype none
module cpom_core
  import cpom_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // Cycle model
  input wire logic cyc_valid,
  input wire cpom_pkg::cpom_cyc_req_t cyc_req,
  input wire logic intermittent_en,
  input wire logic [1:0] clock_gear_select,
  output logic [15:0] total_cyc,
  output logic total_valid,
  // Register write and read
  input wire logic reg_we,
  input wire logic [2:0] reg_idx,
  input wire cpom_pkg::cpom_size_t reg_size,
  input wire logic [31:0] reg_wdata,
  input wire logic [2:0] rd_idx,
  input wire cpom_pkg::cpom_size_t rd_size,
  input wire logic rd_low_four,
  output logic [31:0] reg_rdata,
  // Accumulator
  input wire logic acc_we,
  input wire cpom_pkg::cpom_size_t acc_size,
  input wire cpom_pkg::cpom_upfill_t acc_upfill,
  input wire logic [31:0] acc_wdata,
  output logic [15:0] acc_upper_half,
  output logic [15:0] acc_lower_half,
  // Stack and bank
  input wire logic stack_sys,
  input wire logic [15:0] sp_wdata,
  input wire logic sp_we,
  output logic [15:0] stack_ptr,
  input wire logic bank_we,
  input wire cpom_pkg::cpom_bank_t bank_sel,
  input wire logic bank_no_program,
  input wire logic [7:0] bank_wdata,
  output logic [7:0] bank_rdata,
  output logic bank_illegal,
  // Operand decode
  input wire logic [23:0] physical_direct_address,
  output logic [15:0] addr_lo_field,
  output logic [7:0] addr_hi_field,
  output logic io_area_hit,
  input wire logic [31:0] imm_raw,
  input wire logic [1:0] imm_kind,
  output logic [31:0] imm_value,
  output logic [15:0] sign_extended_short_immediate,
  input wire logic [15:0] disp_raw,
  input wire logic disp_long,
  output logic [15:0] disp_value
);
  import cpom_pkg::*;

  // Sign extend byte to word
  function automatic logic [15:0] sx8(input logic [7:0] v);
    sx8 = {{8{v[7]}}, v};
  endfunction : sx8

  // Word general registers; bytes and longs overlay them
  logic [15:0] word_general_reg [NUM_WORD_REGS];
  logic [15:0] user_stack_pointer;
  logic [15:0] system_stack_pointer;
  logic [7:0] bank_q [7];
  logic [15:0] acc_hi_q;
  logic [15:0] acc_lo_q;
  logic [15:0] total_q;
  logic total_v_q;

  // Fetch cycles for the path
  wire [4:0] words_cross = 5'({1'b0, cyc_req.fetch_bytes} + {4'h0, cyc_req.start_odd}) >> 1;
  logic [7:0] fetch_cyc;
  always_comb begin
    unique case (cyc_req.fetch_path)
      CPOM_FETCH_INT16: fetch_cyc = 8'(words_cross * INT16_WORD_FETCH_CYC);
      CPOM_FETCH_EXT16: fetch_cyc = 8'(words_cross * EXT16_WORD_FETCH_CYC);
      // Widen before the product so fifteen bytes do not wrap
      CPOM_FETCH_EXT8: fetch_cyc = 8'(cyc_req.fetch_bytes) * 8'(EXT8_BYTE_FETCH_CYC);
      default: fetch_cyc = 8'h00;
    endcase
  end
  // Stall length from gear: 0 none, else 4/8/16
  wire [4:0] stall_len = (clock_gear_select == 2'h0) ? 5'h00 : 5'(5'h02 << clock_gear_select);
  // Product widened first; fifteen accesses at sixteen cycles needs eight bits
  wire [8:0] stall_cyc = intermittent_en ? 9'(cyc_req.accesses) * 9'(stall_len) : 9'h000;
  wire [15:0] total_d = 16'(cyc_req.base_cyc) + 16'(cyc_req.corr_cyc) + 16'(fetch_cyc)
                        + 16'(stall_cyc);

  // Latch cycle result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      total_q <= CYC_RST;
      total_v_q <= 1'b0;
    end else begin
      total_v_q <= cyc_valid;
      if (cyc_valid) total_q <= total_d;
    end
  end
  assign total_cyc = total_q;
  assign total_valid = total_v_q;

  // Register file writes by size
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_WORD_REGS; i++) word_general_reg[i] <= REG_RST;
    end else if (reg_we) begin
      unique case (reg_size)
        // Byte reg i is low byte of word reg i
        CPOM_SZ_BYTE: word_general_reg[reg_idx][7:0] <= reg_wdata[7:0];
        CPOM_SZ_WORD: word_general_reg[reg_idx] <= reg_wdata[15:0];
        // Long reg n spans word regs 2n and 2n+1
        CPOM_SZ_LONG: begin
          word_general_reg[{reg_idx[1:0], 1'b0}] <= reg_wdata[15:0];
          word_general_reg[{reg_idx[1:0], 1'b1}] <= reg_wdata[31:16];
        end
        default: ;
      endcase
    end
  end
  // Read mux; low-four class masks index
  wire [2:0] rd_w = rd_low_four ? {1'b0, rd_idx[1:0]} : rd_idx;
  always_comb begin
    unique case (rd_size)
      CPOM_SZ_BYTE: reg_rdata = {24'h000000, word_general_reg[rd_w][7:0]};
      CPOM_SZ_WORD: reg_rdata = {16'h0000, word_general_reg[rd_w]};
      CPOM_SZ_LONG: reg_rdata = {word_general_reg[{rd_idx[1:0], 1'b1}], word_general_reg[{rd_idx[1:0], 1'b0}]};
      default: reg_rdata = 32'h00000000;
    endcase
  end

  // Accumulator with upper-half fill
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_hi_q <= REG_RST;
      acc_lo_q <= REG_RST;
    end else if (acc_we) begin
      unique case (acc_size)
        CPOM_SZ_BYTE: acc_lo_q <= {8'h00, acc_wdata[7:0]};
        CPOM_SZ_WORD: acc_lo_q <= acc_wdata[15:0];
        CPOM_SZ_LONG: acc_lo_q <= acc_wdata[15:0];
        default: ;
      endcase
      if (acc_size == CPOM_SZ_LONG) acc_hi_q <= acc_wdata[31:16];
      else begin
        unique case (acc_upfill)
          CPOM_UP_COPY: acc_hi_q <= acc_lo_q;
          CPOM_UP_ZERO: acc_hi_q <= 16'h0000;
          CPOM_UP_SIGN: acc_hi_q <= {16{acc_lo_q[15]}};
          CPOM_UP_NONE: ;
        endcase
      end
    end
  end
  assign acc_upper_half = acc_hi_q;
  assign acc_lower_half = acc_lo_q;

  // Stack pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_stack_pointer <= REG_RST;
      system_stack_pointer <= REG_RST;
    end else if (sp_we) begin
      if (stack_sys) system_stack_pointer <= sp_wdata;
      else user_stack_pointer <= sp_wdata;
    end
  end
  assign stack_ptr = stack_sys ? system_stack_pointer : user_stack_pointer;

  // Bank registers; current stack bank aliases system or user bank
  wire [2:0] bank_phys = (bank_sel == CPOM_BNK_CURSTK) ?
                         (stack_sys ? 3'(CPOM_BNK_SYSSTK) : 3'(CPOM_BNK_USRSTK)) : 3'(bank_sel);
  assign bank_illegal = bank_no_program && (bank_sel == CPOM_BNK_PROG);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 7; i++) bank_q[i] <= BANK_RST;
    end else if (bank_we && !bank_illegal) begin
      bank_q[bank_phys] <= bank_wdata;
    end
  end
  assign bank_rdata = bank_illegal ? 8'h00 : bank_q[bank_phys];

  // Address, immediate and displacement decode
  assign addr_lo_field = physical_direct_address[ADDR_LO_W-1:0];
  assign addr_hi_field = physical_direct_address[ADDR_LO_W+ADDR_HI_W-1:ADDR_LO_W];
  assign io_area_hit = (physical_direct_address >= IO_AREA_LO) && (physical_direct_address <= IO_AREA_HI);
  assign sign_extended_short_immediate = sx8(imm_raw[7:0]);
  always_comb begin
    unique case (imm_kind)
      2'h0: imm_value = {28'h0000000, imm_raw[3:0]};
      2'h1: imm_value = {24'h000000, imm_raw[7:0]};
      2'h2: imm_value = {16'h0000, imm_raw[15:0]};
      2'h3: imm_value = imm_raw;
    endcase
  end
  assign disp_value = disp_long ? disp_raw : sx8(disp_raw[7:0]);

  // Checks
  AST_TOTAL: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_valid |=> total_valid && total_cyc == $past(total_d))
    else $error("total cycle count wrong");
  AST_STALL: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_valid && !intermittent_en |-> total_d == 16'(cyc_req.base_cyc) + 16'(cyc_req.corr_cyc) + 16'(fetch_cyc))
    else $error("stall added when not intermittent");
  AST_EXT8: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_req.fetch_path == CPOM_FETCH_EXT8 |->
    fetch_cyc == {4'h0, cyc_req.fetch_bytes} + {3'h0, cyc_req.fetch_bytes, 1'b0})
    else $error("byte fetch cycles wrong");
  AST_GEAR3: assert property (@(posedge clk) disable iff (!rst_n)
    intermittent_en && clock_gear_select == 2'h3 |-> stall_cyc == {1'b0, cyc_req.accesses, 4'h0})
    else $error("longest stall wrong");
  AST_SP: assert property (@(posedge clk) disable iff (!rst_n)
    sp_we && stack_sys |=> system_stack_pointer == $past(sp_wdata))
    else $error("system stack pointer not written");
  AST_BANK: assert property (@(posedge clk) disable iff (!rst_n)
    bank_no_program && bank_sel == CPOM_BNK_PROG |-> bank_rdata == 8'h00)
    else $error("program bank visible in second class");
  AST_IO: assert property (@(posedge clk) disable iff (!rst_n)
    io_area_hit |-> physical_direct_address[23:8] == 16'h0000)
    else $error("io window too wide");
  AST_EXT: assert property (@(posedge clk) disable iff (!rst_n)
    sign_extended_short_immediate[15:8] == {8{imm_raw[7]}})
    else $error("sign extension wrong");
  AST_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    acc_we && acc_size != CPOM_SZ_LONG && acc_upfill == CPOM_UP_ZERO |=> acc_upper_half == 16'h0000)
    else $error("upper half not zeroed");
endmodule : cpom_core
`default_nettype wire

// file: src/cpom_pkg.sv
// Package for the operand and cycle model block: field widths, encodings,
// cycle constants and the struct that carries one instruction's cycle figures.
// Assumes a single 25 MHz core clock and no register bus.
package cpom_pkg;

  // Core clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 40;

  // Operand width classes
  typedef enum logic [1:0] {
    CPOM_SZ_BYTE,
    CPOM_SZ_WORD,
    CPOM_SZ_LONG
  } cpom_size_t;

  // Bank register selectors
  typedef enum logic [2:0] {
    CPOM_BNK_DATA,
    CPOM_BNK_ADDDATA,
    CPOM_BNK_SYSSTK,
    CPOM_BNK_USRSTK,
    CPOM_BNK_DPAGE,
    CPOM_BNK_PROG,
    CPOM_BNK_CURSTK
  } cpom_bank_t;

  // Upper half fill modes
  typedef enum logic [1:0] {
    CPOM_UP_NONE,
    CPOM_UP_COPY,
    CPOM_UP_ZERO,
    CPOM_UP_SIGN
  } cpom_upfill_t;

  // Program fetch path
  typedef enum logic [1:0] {
    CPOM_FETCH_INT16,
    CPOM_FETCH_EXT16,
    CPOM_FETCH_EXT8
  } cpom_fetch_t;

  // Fetch cycle corrections
  localparam logic [3:0] INT16_WORD_FETCH_CYC = 4'h2;
  localparam logic [3:0] EXT16_WORD_FETCH_CYC = 4'h3;
  localparam logic [3:0] EXT8_BYTE_FETCH_CYC = 4'h3;

  // Short I/O window bounds
  localparam logic [23:0] IO_AREA_LO = 24'h000000;
  localparam logic [23:0] IO_AREA_HI = 24'h0000ff;

  // Address field split
  localparam int unsigned ADDR_LO_W = 16;
  localparam int unsigned ADDR_HI_W = 8;

  // Register file sizes
  localparam int unsigned NUM_WORD_REGS = 8;
  localparam int unsigned NUM_LONG_REGS = 4;
  localparam int unsigned NUM_LOW_WORD_REGS = 4;

  // Reset values
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [15:0] CYC_RST = 16'h0000;

  // Cycle request for one instruction
  typedef struct packed {
    logic [7:0] base_cyc;
    logic [7:0] corr_cyc;
    logic [3:0] fetch_bytes;
    logic start_odd;
    cpom_fetch_t fetch_path;
    logic [3:0] accesses;
  } cpom_cyc_req_t;

endpackage : cpom_pkg

// file: dv/cpom_mem_model.sv
// Memory side model: program fetch cost charged by the code memory path.
// Assumes the testbench presents one instruction's fetch shape at a time.
`timescale 1ns/1ns
`default_nettype none
module cpom_mem_model
  import cpom_pkg::*;
(
  input wire cpom_pkg::cpom_fetch_t path,
  input wire logic [3:0] n_bytes,
  input wire logic odd,
  output logic [7:0] fetch_cyc
);
  // Words touched when code sits on a 16-bit path
  wire logic [4:0] words = ({1'b0, n_bytes} + {4'h0, odd}) >> 1;
  // Cost per word on 16-bit paths, per byte on the 8-bit bus
  assign fetch_cyc = (path == CPOM_FETCH_EXT8) ? n_bytes * EXT8_BYTE_FETCH_CYC :
    (path == CPOM_FETCH_EXT16) ? words * EXT16_WORD_FETCH_CYC :
    words * INT16_WORD_FETCH_CYC;
endmodule : cpom_mem_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the operand and cycle model block.
// Assumes one 25 MHz clock and the memory side model beside it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cpom_pkg::*;
  logic clk = 0, rst_n = 0, cyc_valid = 0, intermittent_en = 0, reg_we = 0, rd_low_four = 0;
  logic acc_we = 0, stack_sys = 0, sp_we = 0, bank_we = 0, bank_no_program = 0, disp_long = 0;
  logic [1:0] clock_gear_select = 0, imm_kind = 0;
  logic [2:0] reg_idx = 0, rd_idx = 0;
  logic [7:0] bank_wdata = 0, bank_rdata, addr_hi_field, fc;
  logic [15:0] total_cyc, acc_upper_half, acc_lower_half, stack_ptr, addr_lo_field, disp_value;
  logic [15:0] sp_wdata = 0, disp_raw = 0, sign_extended_short_immediate;
  logic [23:0] physical_direct_address = 0;
  logic [31:0] reg_wdata = 0, acc_wdata = 0, imm_raw = 0, reg_rdata, imm_value;
  logic total_valid, bank_illegal, io_area_hit, odd = 0;
  logic [3:0] nb = 0;
  cpom_cyc_req_t cyc_req = '0;
  cpom_size_t reg_size = CPOM_SZ_BYTE, rd_size = CPOM_SZ_BYTE, acc_size = CPOM_SZ_BYTE;
  cpom_upfill_t acc_upfill = CPOM_UP_NONE;
  cpom_bank_t bank_sel = CPOM_BNK_DATA;
  cpom_fetch_t fp = CPOM_FETCH_INT16;
  int n_fail = 0, checked = 0;
  cpom_core dut (
    .clk(clk), .rst_n(rst_n), .cyc_valid(cyc_valid), .cyc_req(cyc_req),
    .intermittent_en(intermittent_en), .clock_gear_select(clock_gear_select),
    .total_cyc(total_cyc), .total_valid(total_valid), .reg_we(reg_we), .reg_idx(reg_idx),
    .reg_size(reg_size), .reg_wdata(reg_wdata), .rd_idx(rd_idx), .rd_size(rd_size),
    .rd_low_four(rd_low_four), .reg_rdata(reg_rdata), .acc_we(acc_we), .acc_size(acc_size),
    .acc_upfill(acc_upfill), .acc_wdata(acc_wdata), .acc_upper_half(acc_upper_half),
    .acc_lower_half(acc_lower_half), .stack_sys(stack_sys), .sp_wdata(sp_wdata), .sp_we(sp_we),
    .stack_ptr(stack_ptr), .bank_we(bank_we), .bank_sel(bank_sel), .bank_no_program(bank_no_program),
    .bank_wdata(bank_wdata), .bank_rdata(bank_rdata), .bank_illegal(bank_illegal),
    .physical_direct_address(physical_direct_address), .addr_lo_field(addr_lo_field),
    .addr_hi_field(addr_hi_field), .io_area_hit(io_area_hit), .imm_raw(imm_raw), .imm_kind(imm_kind),
    .imm_value(imm_value), .sign_extended_short_immediate(sign_extended_short_immediate),
    .disp_raw(disp_raw), .disp_long(disp_long), .disp_value(disp_value)
  );
  cpom_mem_model mem (.path(fp), .n_bytes(nb), .odd(odd), .fetch_cyc(fc));
  // Free running core clock
  initial forever #20 clk = ~clk;
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Every fetch path, gear and stall mode
  task cycles;
    logic [7:0] st;
    for (int p = 0; p < 3; p++) for (int g = 0; g < 5; g++) begin
      @(posedge clk);
      fp <= cpom_fetch_t'(p);
      nb <= 4'h5;
      odd <= 1'b1;
      cyc_valid <= 1'b1;
      cyc_req <= '{8'h0a, 8'h02, 4'h5, 1'b1, cpom_fetch_t'(p), 4'h3};
      intermittent_en <= (g < 4);
      // Last pass keeps the longest gear with intermittent mode off
      clock_gear_select <= (g == 4) ? 2'h3 : g[1:0];
      st = (g == 0 || g == 4) ? 8'h00 : (8'h02 << g);
      @(posedge clk);
      cyc_valid <= 1'b0;
      #1 check(total_valid, 1);
      check(total_cyc, 16'h000c + fc + 8'h03 * st);
    end
  endtask : cycles
  // Long write seen as word and byte registers
  task regs;
    @(posedge clk);
    reg_we <= 1'b1;
    reg_idx <= 3'h1;
    reg_size <= CPOM_SZ_LONG;
    reg_wdata <= 32'h89abcdef;
    @(posedge clk);
    reg_we <= 1'b0;
    rd_idx <= 3'h2;
    rd_size <= CPOM_SZ_WORD;
    #1 check(reg_rdata, 32'h0000cdef);
    // Index seven folds to three in the low-four class
    @(posedge clk);
    rd_idx <= 3'h7;
    rd_low_four <= 1'b1;
    #1 check(reg_rdata, 32'h000089ab);
    @(posedge clk);
    rd_idx <= 3'h2;
    rd_size <= CPOM_SZ_BYTE;
    #1 check(reg_rdata, 32'h000000ef);
    @(posedge clk);
    rd_idx <= 3'h1;
    rd_size <= CPOM_SZ_LONG;
    #1 check(reg_rdata, 32'h89abcdef);
  endtask : regs
  // One accumulator write, then both halves
  task acc(input cpom_size_t s, input cpom_upfill_t f, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    acc_we <= 1'b1;
    acc_size <= s;
    acc_upfill <= f;
    acc_wdata <= d;
    @(posedge clk);
    acc_we <= 1'b0;
    #1 check({acc_upper_half, acc_lower_half}, e);
  endtask : acc
  // Stack pointer select and write
  task sp(input logic sys, input logic we, input logic [15:0] d, input logic [15:0] e);
    @(posedge clk);
    stack_sys <= sys;
    sp_we <= we;
    sp_wdata <= d;
    @(posedge clk);
    sp_we <= 1'b0;
    #1 check(stack_ptr, e);
  endtask : sp
  // Bank write attempt and read back
  task bk(input int s, input logic np, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk);
    bank_sel <= cpom_bank_t'(s);
    bank_no_program <= np;
    bank_we <= 1'b1;
    bank_wdata <= d;
    @(posedge clk);
    bank_we <= 1'b0;
    #1 check(bank_rdata, e);
    check(bank_illegal, np && s == 5);
  endtask : bk
  // Read one bank register with no write
  task peek(input int s, input logic [7:0] e);
    @(posedge clk);
    bank_sel <= cpom_bank_t'(s);
    bank_no_program <= 1'b0;
    #1 check(bank_rdata, e);
  endtask : peek
  // Address split, I/O window, immediates and displacements
  task decode;
    logic [31:0] ie [4] = '{32'h9, 32'hf9, 32'h43f9, 32'h876543f9};
    @(posedge clk);
    physical_direct_address <= 24'h0000ff;
    imm_raw <= 32'h876543f9;
    disp_raw <= 16'h1280;
    #1 check(io_area_hit, 1);
    check(sign_extended_short_immediate, 16'hfff9);
    check(disp_value, 16'hff80);
    @(posedge clk);
    physical_direct_address <= 24'habcd00;
    disp_long <= 1'b1;
    #1 check(io_area_hit, 0);
    check({addr_hi_field, addr_lo_field}, 24'habcd00);
    check(disp_value, 16'h1280);
    @(posedge clk);
    physical_direct_address <= 24'h000100;
    #1 check(io_area_hit, 0);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      imm_kind <= k[1:0];
      #1 check(imm_value, ie[k]);
    end
  endtask : decode
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1 check({acc_upper_half, acc_lower_half}, 0);
    check(total_cyc, 0);
    cycles;
    regs;
    acc(CPOM_SZ_LONG, CPOM_UP_NONE, 32'h12348765, 32'h12348765);
    acc(CPOM_SZ_WORD, CPOM_UP_SIGN, 32'h00000001, 32'hffff0001);
    acc(CPOM_SZ_BYTE, CPOM_UP_ZERO, 32'h000001ff, 32'h000000ff);
    acc(CPOM_SZ_WORD, CPOM_UP_COPY, 32'h00004321, 32'h00ff4321);
    sp(1'b1, 1'b1, 16'h1111, 16'h1111);
    sp(1'b0, 1'b1, 16'h2222, 16'h2222);
    sp(1'b1, 1'b0, 16'h0000, 16'h1111);
    for (int b = 0; b < 6; b++) bk(b, 1'b0, 8'h10 + b[7:0], 8'h10 + b[7:0]);
    // Refused write reads zero, then the old value shows in the full class
    bk(5, 1'b1, 8'hee, 8'h00);
    peek(5, 8'h15);
    // Current stack bank lands in the system bank, then the user bank
    bk(6, 1'b0, 8'h22, 8'h22);
    peek(2, 8'h22);
    sp(1'b0, 1'b0, 16'h0000, 16'h2222);
    bk(6, 1'b0, 8'h33, 8'h33);
    peek(3, 8'h33);
    peek(2, 8'h22);
    decode;
    complete_run;
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule : testbench
`default_nettype wire
